//--- rtl/rcr_pkg.sv
// Constants shared by the regulator control register bank.
package rcr_pkg;
	// ==========================================================
	// Register offsets.
	localparam logic [7:0] ADDR_BKP = 8'h1E; // Backup regulator.
	localparam logic [7:0] ADDR_IO  = 8'h20; // I/O converter.
	localparam logic [7:0] ADDR_CC  = 8'h21; // Core converter.
	localparam logic [7:0] ADDR_TP  = 8'h22; // Primary target.
	localparam logic [7:0] ADDR_TA  = 8'h23; // Alternate target.
	// ==========================================================
	// Writable bit masks; other bits are reserved and read zero, save the backup state field.
	localparam logic [7:0] MASK_BKP = 8'h08;
	localparam logic [7:0] MASK_IO  = 8'hCF;
	localparam logic [7:0] MASK_TA  = 8'h7F;
	// ==========================================================
	// Field positions.
	localparam int KEEP_BIT  = 3; // Backup full-load in OFF.
	localparam int MODE_LSB  = 0; // Power mode, two bits.
	localparam int IOV_LSB   = 2; // I/O voltage code.
	localparam int ILIM_LSB  = 6; // I/O current limit.
	localparam int RAMP_LSB  = 2; // Core ramp rate, three bits.
	localparam int CILIM_BIT = 5; // Core current limit.
	localparam int GAIN_LSB  = 6; // Core output multiplier.
	localparam int SELB_BIT  = 7; // Target select.
	// ==========================================================
	// Reset values.
	localparam logic [1:0] BKP_MODE_RST = 2'h1; // Active high power.
	localparam logic [7:0] IO_RST       = 8'h00;
	localparam logic [7:0] CC_RST       = 8'h0C; // Ramp rate 0x3.
	localparam logic [7:0] TGT_RST      = 8'h00;
	// ==========================================================
	// Output level in 12.5 mV units.
	localparam int         LVL_W      = 9;
	localparam logic [8:0] LVL_OFS    = 9'h02D; // 0.5625 V.
	localparam logic [6:0] CODE_LOW   = 7'h03;  // Floor 0.6 V.
	localparam logic [6:0] CODE_TOP   = 7'h4B;  // Ceiling 1.5 V.
	localparam logic [8:0] LVL_MAX    = 9'h108; // 3.3 V.
	// ==========================================================
	// Ramp timing: each step interval lasts the ramp-rate code plus one units.
	localparam int CLK_NS       = 10;
	localparam int RAMP_UNIT_NS = 1000;
	localparam int RAMP_UNIT_CYC = RAMP_UNIT_NS / CLK_NS;
	// Ramp engine states.
	typedef enum logic [1:0] {
		RCR_IDLE = 2'b01,
		RCR_MOVE = 2'b10
	} rcr_ramp_e;
endpackage

//--- rtl/rcr_regs.sv
// Control register bank for backup, I/O and first core rails.
// Function
// [RULE_01] Off-mask set keeps backup full load when off.
// [RULE_02] Off-mask clear puts backup low-power when off.
// [RULE_03] On backup supply, backup always low-power.
// [RULE_04] Backup state reads only; test mode writes.
// [RULE_05] I/O current limit codes 0.6/1.0/1.3 A.
// [RULE_06] I/O voltage code picks 1.5-3.3 V.
// [RULE_07] I/O power mode off, active or sleep.
// [RULE_08] Core multiplier gain one, two or three.
// [RULE_09] Core ramps in 12.5 mV timed steps.
// [RULE_10] Core power mode off, high or low.
// [RULE_11] Primary bit 7 picks applied target register.
// [RULE_12] Core code maps to output level.
// [RULE_13] Core output never exceeds 3.3 V.
// [RULE_14] Target registers follow chosen access port.
// [RULE_15] Boot configuration seeds selected fields.
// [RULE_16] Backup register in general reset domain.
// [RULE_17] Converter registers in turn-off reset domain.
// [RULE_18] Reserved bits read zero, ignore writes.
// [RULE_19] Target change restarts the stepped ramp.
module rcr_regs
	import rcr_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_turnoff_rst_b,
	input  wire logic       i_test_mode,
	input  wire logic       i_dev_off,
	input  wire logic       i_on_backup,
	input  wire logic       i_scaling_port_choice,
	input  wire logic       i_ramp_bypass,
	input  wire logic       i_boot_keep,
	input  wire logic [1:0] i_boot_io_vsel,
	input  wire logic [1:0] i_boot_gain,
	input  wire logic [6:0] i_boot_code_p,
	input  wire logic [6:0] i_boot_code_a,
	input  wire logic       i_ctl_wr,
	input  wire logic       i_ctl_rd,
	input  wire logic [7:0] i_ctl_addr,
	input  wire logic [7:0] i_ctl_wdata,
	output logic      [7:0] o_ctl_rdata,
	input  wire logic       i_vs_wr,
	input  wire logic       i_vs_rd,
	input  wire logic [7:0] i_vs_addr,
	input  wire logic [7:0] i_vs_wdata,
	output logic      [7:0] o_vs_rdata,
	output logic            o_bkp_full_load,
	output logic            o_bkp_low_power,
	output logic            o_io_enable,
	output logic            o_io_low_power,
	output logic      [1:0] o_io_ilim,
	output logic      [1:0] o_io_vsel,
	output logic            o_core_enable,
	output logic            o_core_low_power,
	output logic            o_core_ilim,
	output logic      [1:0] o_core_gain,
	output logic      [8:0] o_core_level,
	output logic            o_core_ramping
);
	// ==========================================================
	// Helpers.
	// Gain factor of a multiplier code.
	function automatic logic [1:0] gain_of(input logic [1:0] s);
		return (s == 2'h3) ? 2'h3 : ((s == 2'h2) ? 2'h2 : 2'h1);
	endfunction
	// Output level in 12.5 mV units, clamped to the ceiling.
	function automatic logic [8:0] level_of(input logic [6:0] c,
		input logic [1:0] g);
		logic [6:0]  k;
		logic [10:0] v;
		k = (c < CODE_LOW) ? CODE_LOW : c;
		k = (k > CODE_TOP) ? CODE_TOP : k;
		v = 11'({2'h0, k} + LVL_OFS) * 11'(g); // RULE_08 RULE_12
		if (c == 7'h00) v = 11'h000; // RULE_12
		if (v > 11'(LVL_MAX)) v = 11'(LVL_MAX); // RULE_13
		return v[8:0];
	endfunction
	// Cycles between steps for a ramp-rate code.
	function automatic logic [15:0] step_cyc(input logic [2:0] r);
		return 16'((int'(r) + 1) * RAMP_UNIT_CYC);
	endfunction

	// ==========================================================
	// Register state.
	logic       keep_q;     // Backup keep-full-load bit.
	logic [1:0] bkp_mode_q; // Backup regulator state.
	logic       gen_boot_q; // Boot values still to load, general.
	logic       off_boot_q; // Boot values still to load, turn-off.
	logic [7:0] io_q;       // I/O converter control.
	logic [7:0] cc_q;       // Core converter control.
	logic [7:0] tp_q;       // Primary target.
	logic [7:0] ta_q;       // Alternate target.
	// Target registers listen to only one port at a time.
	logic       v_wr;
	logic [7:0] v_addr;
	logic [7:0] v_wdata;
	assign v_wr    = i_scaling_port_choice ? i_vs_wr : i_ctl_wr;
	assign v_addr  = i_scaling_port_choice ? i_vs_addr : i_ctl_addr;
	assign v_wdata = i_scaling_port_choice ? i_vs_wdata : i_ctl_wdata;

	// Backup register lives in the general reset domain.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin // RULE_16
		if (!i_rst_b) begin
			keep_q     <= 1'b0; // RULE_02
			bkp_mode_q <= BKP_MODE_RST; // RULE_04
			gen_boot_q <= 1'b1;
		end else begin
			gen_boot_q <= 1'b0;
			if (gen_boot_q) begin
				keep_q <= i_boot_keep; // RULE_15
			end else if (i_ctl_wr && i_ctl_addr == ADDR_BKP) begin
				keep_q <= i_ctl_wdata[KEEP_BIT];
				// State field takes writes only in test mode.
				if (i_test_mode) begin // RULE_04
					bkp_mode_q <= i_ctl_wdata[MODE_LSB +: 2];
				end
			end
		end
	end

	// Converter registers live in the turn-off reset domain.
	// Boot values load on the first edge after release, not
	// under the reset itself, so no port feeds an async load.
	always_ff @(posedge i_sys_clk or negedge i_turnoff_rst_b) begin
		if (!i_turnoff_rst_b) begin // RULE_17
			io_q       <= IO_RST;
			cc_q       <= CC_RST;
			tp_q       <= TGT_RST;
			ta_q       <= TGT_RST;
			off_boot_q <= 1'b1;
		end else begin
			off_boot_q <= 1'b0;
			if (off_boot_q) begin // RULE_15
				io_q[IOV_LSB +: 2]  <= i_boot_io_vsel;
				cc_q[GAIN_LSB +: 2] <= i_boot_gain;
				tp_q[6:0]           <= i_boot_code_p;
				ta_q[6:0]           <= i_boot_code_a;
			end else begin
				// Control port always owns the converter controls.
				if (i_ctl_wr && i_ctl_addr == ADDR_IO) begin
					io_q <= i_ctl_wdata & MASK_IO; // RULE_18
				end
				if (i_ctl_wr && i_ctl_addr == ADDR_CC) begin
					cc_q <= i_ctl_wdata;
				end
				if (v_wr && v_addr == ADDR_TP) begin // RULE_14
					tp_q <= v_wdata;
				end
				if (v_wr && v_addr == ADDR_TA) begin // RULE_14
					ta_q <= v_wdata & MASK_TA; // RULE_18
				end
			end
		end
	end

	// ==========================================================
	// Read path; a port reads targets only while it owns them.
	function automatic logic [7:0] rd_mux(input logic [7:0] a,
		input logic own_v, input logic own_c);
		logic [7:0] d;
		d = 8'h00;
		if (own_c && a == ADDR_BKP) begin
			d = {4'h0, keep_q, 1'b0, bkp_mode_q}; // RULE_18
		end
		if (own_c && a == ADDR_IO) d = io_q;
		if (own_c && a == ADDR_CC) d = cc_q;
		if (own_v && a == ADDR_TP) d = tp_q;
		if (own_v && a == ADDR_TA) d = ta_q;
		return d;
	endfunction

	// Read data is captured on the read strobe and held.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ctl_rdata <= 8'h00;
			o_vs_rdata  <= 8'h00;
		end else begin
			if (i_ctl_rd) begin
				o_ctl_rdata <= rd_mux(i_ctl_addr,
					!i_scaling_port_choice, 1'b1);
			end
			if (i_vs_rd) begin
				o_vs_rdata <= rd_mux(i_vs_addr,
					i_scaling_port_choice, 1'b0);
			end
		end
	end

	// ==========================================================
	// Backup regulator drive; backup supply forces low power.
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bkp_full_load <= 1'b0;
			o_bkp_low_power <= 1'b0;
		end else begin
			o_bkp_full_load <= i_dev_off && keep_q
				&& !i_on_backup; // RULE_01 RULE_03
			o_bkp_low_power <= i_on_backup
				|| (i_dev_off && !keep_q); // RULE_02 RULE_03
		end
	end

	// ==========================================================
	// Converter mode and option outputs.
	always_ff @(posedge i_sys_clk or negedge i_turnoff_rst_b) begin
		if (!i_turnoff_rst_b) begin
			o_io_enable      <= 1'b0;
			o_io_low_power   <= 1'b0;
			o_io_ilim        <= 2'h0;
			o_io_vsel        <= 2'h0;
			o_core_enable    <= 1'b0;
			o_core_low_power <= 1'b0;
			o_core_ilim      <= 1'b0;
			o_core_gain      <= 2'h1;
		end else begin
			// Low mode bit clear means off for 00 and 10.
			o_io_enable    <= io_q[MODE_LSB]; // RULE_07
			o_io_low_power <= &io_q[MODE_LSB +: 2]; // RULE_07
			// Codes 10 and 11 both give the top limit.
			o_io_ilim <= io_q[ILIM_LSB + 1] ? 2'h2
				: io_q[ILIM_LSB +: 2]; // RULE_05
			o_io_vsel        <= io_q[IOV_LSB +: 2]; // RULE_06
			o_core_enable    <= cc_q[MODE_LSB]; // RULE_10
			o_core_low_power <= &cc_q[MODE_LSB +: 2]; // RULE_10
			o_core_ilim      <= cc_q[CILIM_BIT];
			o_core_gain      <= gain_of(cc_q[GAIN_LSB +: 2]); // RULE_08
		end
	end

	// ==========================================================
	// Ramp engine: one 12.5 mV unit per step interval.
	rcr_ramp_e   ramp_q;
	logic [8:0]  tgt_q;   // Applied target level.
	logic [8:0]  tgt_d;
	logic [15:0] cnt_q;   // Cycles left until the next step.
	assign tgt_d = level_of(tp_q[SELB_BIT] ? ta_q[6:0] : tp_q[6:0],
		gain_of(cc_q[GAIN_LSB +: 2])); // RULE_11

	// A new target reloads the interval so every ramp starts fresh.
	always_ff @(posedge i_sys_clk or negedge i_turnoff_rst_b) begin
		if (!i_turnoff_rst_b) begin
			ramp_q         <= RCR_IDLE;
			tgt_q          <= 9'h000;
			cnt_q          <= 16'h0000;
			o_core_level   <= 9'h000;
			o_core_ramping <= 1'b0;
		end else begin
			tgt_q          <= tgt_d;
			o_core_ramping <= (o_core_level != tgt_q);
			if (tgt_d != tgt_q) begin // RULE_19
				cnt_q  <= step_cyc(cc_q[RAMP_LSB +: 3]);
				ramp_q <= RCR_MOVE;
			end else if (i_ramp_bypass) begin
				o_core_level <= tgt_q; // RULE_09
				ramp_q       <= RCR_IDLE;
			end else begin
				unique case (ramp_q)
					RCR_IDLE: begin
						if (o_core_level != tgt_q) begin
							cnt_q  <= step_cyc(cc_q[RAMP_LSB +: 3]);
							ramp_q <= RCR_MOVE;
						end
					end
					RCR_MOVE: begin
						if (o_core_level == tgt_q) begin
							ramp_q <= RCR_IDLE;
						end else if (cnt_q > 16'h0001) begin
							cnt_q <= cnt_q - 16'h0001;
						end else begin
							// Step one unit toward the target.
							o_core_level <= (o_core_level < tgt_q)
								? o_core_level + 9'h001
								: o_core_level - 9'h001; // RULE_09
							cnt_q <= step_cyc(cc_q[RAMP_LSB +: 3]);
						end
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Checks.
	keep_load_a: assert property (@(posedge i_sys_clk) // RULE_01
		disable iff (!i_rst_b)
		(keep_q && i_dev_off && !i_on_backup) |=> o_bkp_full_load)
		else $error("Backup lost full load in OFF.");
	off_lowpwr_a: assert property (@(posedge i_sys_clk) // RULE_02
		disable iff (!i_rst_b)
		(!keep_q && i_dev_off) |=> o_bkp_low_power)
		else $error("Backup not low power in OFF.");
	backup_supply_a: assert property (@(posedge i_sys_clk) // RULE_03
		disable iff (!i_rst_b)
		i_on_backup |=> (o_bkp_low_power && !o_bkp_full_load))
		else $error("Backup supply did not force low power.");
	state_ro_a: assert property (@(posedge i_sys_clk) // RULE_04
		disable iff (!i_rst_b)
		(!i_test_mode && !gen_boot_q) |=> $stable(bkp_mode_q))
		else $error("Backup state changed outside test mode.");
	io_mode_a: assert property (@(posedge i_sys_clk) // RULE_07
		disable iff (!i_turnoff_rst_b)
		##1 o_io_enable == $past(io_q[MODE_LSB]))
		else $error("I/O enable does not follow mode.");
	level_cap_a: assert property (@(posedge i_sys_clk) // RULE_13
		disable iff (!i_turnoff_rst_b)
		o_core_level <= LVL_MAX)
		else $error("Core level above ceiling.");
	step_size_a: assert property (@(posedge i_sys_clk) // RULE_09
		disable iff (!i_turnoff_rst_b)
		(!i_ramp_bypass && $stable(tgt_q)) ##1 !$stable(o_core_level)
		|-> ($past(o_core_level) - o_core_level == 9'h001
		|| o_core_level - $past(o_core_level) == 9'h001))
		else $error("Core level moved more than one step.");
	port_own_a: assert property (@(posedge i_sys_clk) // RULE_14
		disable iff (!i_turnoff_rst_b)
		(!off_boot_q && !i_ctl_wr && !i_vs_wr) |=> $stable(tp_q))
		else $error("Primary target changed with no write.");
	resv_zero_a: assert property (@(posedge i_sys_clk) // RULE_18
		disable iff (!i_rst_b)
		(i_ctl_rd && i_ctl_addr == ADDR_IO) |=> o_ctl_rdata[5:4] == 2'h0)
		else $error("Reserved I/O bits read nonzero.");
endmodule

//--- dv/rcr_host.sv
// Host model that drives one register port of the bank.
module rcr_host (
	input  wire logic       i_sys_clk,
	input  wire logic [7:0] i_rdata,
	output logic            o_wr,
	output logic            o_rd,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Idle port at time zero.
	initial begin
		o_wr    = 1'b0;
		o_rd    = 1'b0;
		o_addr  = 8'h00;
		o_wdata = 8'h00;
	end
	// ==========================================================
	// Single-byte write, entered just after a rising edge.
	// A released bus shows the inverse, so stale data never matches.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_sys_clk);
		o_wr    <= 1'b0;
		o_addr  <= ~a;
		o_wdata <= ~d;
		@(posedge i_sys_clk);
	endtask
	// Single-byte read; data stands just after the taking edge.
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_sys_clk);
		o_rd   <= 1'b0;
		o_addr <= ~a;
		#1 d = i_rdata;
		@(posedge i_sys_clk);
	endtask
endmodule

//--- dv/test_rcr_regs.sv
// Self-checking bench for the regulator control register bank.
module test_rcr_regs
	import rcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Stimulus and observed signals.
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       toff_b = 1'b0;
	logic       tmode = 1'b0;
	logic       off = 1'b0;
	logic       bkp = 1'b0;
	logic       choice = 1'b0;
	logic       bypass = 1'b1;
	logic [7:0] c_addr, c_wd, c_rdata, v_addr, v_wd, v_rdata;
	logic       c_wr, c_rd, v_wr, v_rd, full, bkp_lp, io_en, io_lp;
	logic [1:0] io_ilim, io_vsel, gain;
	logic       core_en, core_lp, core_ilim, ramping;
	logic [8:0] level;
	int         error_cnt = 0;
	int         compares = 0;
	int         cycles = 0;
	always #5 clk = ~clk;
	rcr_host u_ctl (.i_sys_clk(clk), .i_rdata(c_rdata), .o_wr(c_wr),
		.o_rd(c_rd), .o_addr(c_addr), .o_wdata(c_wd));
	rcr_host u_vs (.i_sys_clk(clk), .i_rdata(v_rdata), .o_wr(v_wr),
		.o_rd(v_rd), .o_addr(v_addr), .o_wdata(v_wd));
	// Boot values are distinct from the fixed reset constants.
	rcr_regs u_dut (.i_sys_clk(clk), .i_rst_b(rst_b),
		.i_turnoff_rst_b(toff_b), .i_test_mode(tmode), .i_dev_off(off),
		.i_on_backup(bkp), .i_scaling_port_choice(choice),
		.i_ramp_bypass(bypass), .i_boot_keep(1'b1), .i_boot_io_vsel(2'h2),
		.i_boot_gain(2'h1), .i_boot_code_p(7'h10), .i_boot_code_a(7'h20),
		.i_ctl_wr(c_wr), .i_ctl_rd(c_rd), .i_ctl_addr(c_addr),
		.i_ctl_wdata(c_wd), .o_ctl_rdata(c_rdata), .i_vs_wr(v_wr),
		.i_vs_rd(v_rd), .i_vs_addr(v_addr), .i_vs_wdata(v_wd),
		.o_vs_rdata(v_rdata), .o_bkp_full_load(full),
		.o_bkp_low_power(bkp_lp), .o_io_enable(io_en),
		.o_io_low_power(io_lp), .o_io_ilim(io_ilim), .o_io_vsel(io_vsel),
		.o_core_enable(core_en), .o_core_low_power(core_lp),
		.o_core_ilim(core_ilim), .o_core_gain(gain), .o_core_level(level),
		.o_core_ramping(ramping));
	// ==========================================================
	// Shared helpers.
	task automatic chk(input string n, input logic [8:0] s,
		input logic [8:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_ctl.rd_reg(a, d);
		chk("ctl_rdata", {1'b0, d}, {1'b0, e});
	endtask
	task automatic complete_run;
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// A hang is cut short well past the expected run length.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			error_cnt++;
			complete_run();
		end
	end
	// ==========================================================
	// Scenarios.
	task automatic boot_values;
		rd_chk(ADDR_BKP, 8'h09);
		rd_chk(ADDR_IO, 8'h08);
		rd_chk(ADDR_CC, 8'h4C);
		rd_chk(ADDR_TP, 8'h10);
		rd_chk(ADDR_TA, 8'h20);
		rd_chk(8'h1F, 8'h00);
	endtask
	task automatic backup_modes;
		u_ctl.wr_reg(ADDR_BKP, 8'hF7);
		rd_chk(ADDR_BKP, 8'h01);
		tmode <= 1'b1;
		u_ctl.wr_reg(ADDR_BKP, 8'hFF);
		rd_chk(ADDR_BKP, 8'h0B);
		tmode <= 1'b0;
		off <= 1'b1;
		tick(3);
		chk("full_load", full, 1'b1);
		bkp <= 1'b1;
		tick(3);
		chk("low_power", bkp_lp, 1'b1);
		chk("full_load", full, 1'b0);
		bkp <= 1'b0;
		u_ctl.wr_reg(ADDR_BKP, 8'h00);
		tick(2);
		chk("low_power", bkp_lp, 1'b1);
		chk("full_load", full, 1'b0);
		off <= 1'b0;
	endtask
	// Every code of the I/O fields, reserved bits written as ones.
	task automatic io_codes;
		logic [7:0] d;
		for (int c = 0; c < 4; c++) begin
			d = {c[1:0], 2'b11, c[1:0], c[1:0]};
			u_ctl.wr_reg(ADDR_IO, d);
			rd_chk(ADDR_IO, d & 8'hCF);
			chk("io_ilim", io_ilim, (c == 3) ? 2'h2 : c[1:0]);
			chk("io_vsel", io_vsel, c[1:0]);
			chk("io_enable", io_en, c[0]);
			chk("io_low_power", io_lp, c == 3);
		end
	endtask
	task automatic core_codes;
		logic [8:0] lv[4] = '{9'd77, 9'd77, 9'd154, 9'd231};
		logic [8:0] cl[4] = '{9'd0, 9'd144, 9'd255, 9'd264};
		logic [6:0] cd[4] = '{7'd0, 7'd2, 7'd40, 7'd127};
		u_ctl.wr_reg(ADDR_TP, 8'h20);
		for (int g = 0; g < 4; g++) begin
			u_ctl.wr_reg(ADDR_CC, {g[1:0], 4'h8, g[1:0]});
			tick(4);
			chk("core_gain", gain, (g < 2) ? 2'h1 : g[1:0]);
			chk("core_level", level, lv[g]);
			chk("core_enable", core_en, g[0]);
			chk("core_low", core_lp, g == 3);
			chk("core_ilim", core_ilim, 1'b1);
		end
		for (int i = 0; i < 4; i++) begin
			u_ctl.wr_reg(ADDR_TP, {1'b0, cd[i]});
			tick(4);
			chk("core_level", level, cl[i]);
		end
	endtask
	task automatic port_choice;
		logic [7:0] d;
		choice <= 1'b1;
		u_ctl.wr_reg(ADDR_TP, 8'h00);
		rd_chk(ADDR_TP, 8'h00);
		u_vs.wr_reg(ADDR_TA, 8'h85);
		u_vs.wr_reg(ADDR_TP, 8'hA0);
		u_vs.rd_reg(ADDR_TA, d);
		chk("vs_rdata", {1'b0, d}, 9'h005);
		u_vs.rd_reg(ADDR_IO, d);
		chk("vs_rdata", {1'b0, d}, 9'h000);
		chk("core_level", level, 9'd150);
		choice <= 1'b0;
		rd_chk(ADDR_TP, 8'hA0);
	endtask
	// Fastest ramp: one step each 100 cycles; a new target restarts it.
	task automatic ramp_steps;
		u_ctl.wr_reg(ADDR_CC, 8'h01);
		u_ctl.wr_reg(ADDR_TP, 8'h20);
		tick(4);
		bypass <= 1'b0;
		u_ctl.wr_reg(ADDR_TP, 8'h23);
		tick(148);
		chk("core_level", level, 9'd78);
		chk("core_ramping", ramping, 1'b1);
		u_ctl.wr_reg(ADDR_TP, 8'h20);
		tick(60);
		chk("core_level", level, 9'd78);
		tick(100);
		chk("core_level", level, 9'd77);
		chk("core_ramping", ramping, 1'b0);
	endtask
	task automatic reset_domains;
		u_ctl.wr_reg(ADDR_IO, 8'h41);
		rst_b <= 1'b0;
		tick(2);
		rst_b <= 1'b1;
		tick(2);
		rd_chk(ADDR_IO, 8'h41);
		rd_chk(ADDR_BKP, 8'h09);
		toff_b <= 1'b0;
		tick(2);
		toff_b <= 1'b1;
		tick(2);
		rd_chk(ADDR_IO, 8'h08);
	endtask
	// ==========================================================
	// Main sequence.
	initial begin
		tick(12);
		rst_b <= 1'b1;
		toff_b <= 1'b1;
		tick(2);
		boot_values();
		backup_modes();
		io_codes();
		core_codes();
		port_choice();
		ramp_steps();
		reset_domains();
		complete_run();
	end
endmodule
